// >>> shared/cdp_pkg.sv
// Purpose: Shared constants and types of the clock divider and power mode block
// Assumes: 32-bit AHB-Lite register bus, one 25 MHz input clock
// Notes:   Offsets are byte addresses within the slave window
package cdp_pkg;
  localparam logic [7:0]  OFS_LOCK   = 8'h00;
  localparam logic [7:0]  OFS_MCFG   = 8'h04;
  localparam logic [7:0]  OFS_UCFG   = 8'h08;
  localparam logic [7:0]  OFS_CTRL   = 8'h0c;
  localparam logic [7:0]  OFS_SLOW   = 8'h10;
  localparam logic [7:0]  OFS_RATIO  = 8'h14;
  localparam logic [7:0]  OFS_STAT   = 8'h18;

  localparam logic [23:0] LOCK_RST   = 24'hffffff;
  localparam int          LOCK_W     = 12;
  localparam int          LOCK_M_LSB = 0;
  localparam int          LOCK_U_LSB = 12;
  localparam logic [19:0] PLLCFG_RST = 20'h00000;
  localparam logic [15:0] PERI_RST   = 16'hffff;
  localparam int          CTRL_IDLE  = 16;
  localparam int          CTRL_OFF   = 17;
  localparam logic [7:0]  SLOW_RST   = 8'h00;
  localparam logic [2:0]  RATIO_RST  = 3'h0;

  // Least PLL settling time against the programmed main count
  localparam int          CLK_MHZ      = 25;
  localparam int          LOCK_MIN_US  = 150;
  localparam logic [11:0] LOCK_MIN_CYC = 12'(LOCK_MIN_US * CLK_MHZ);

  typedef struct packed {
    logic       usbOff;
    logic       rsvd6;
    logic       mainOff;
    logic       slowOn;
    logic       rsvd3;
    logic [2:0] val;
  } cdp_slow_s;

  typedef struct packed {
    logic quarter;
    logic half;
    logic periph;
  } cdp_ratio_s;

  typedef enum logic [2:0] {
    CS_XTAL = 3'h0, CS_LOCK = 3'h1, CS_PLL = 3'h3, CS_SLOW = 3'h2, CS_SLOWLOCK = 3'h6
  } cdp_core_e;

  typedef enum logic [1:0] {
    US_XTAL = 2'h0, US_LOCK = 2'h1, US_PLL = 2'h3, US_OFF = 2'h2
  } cdp_usb_e;

  typedef enum logic [1:0] {
    PM_RUN = 2'h0, PM_IDLE = 2'h1, PM_OFF = 2'h2
  } cdp_mode_e;
endpackage : cdp_pkg

// >>> hdl/cdp_lock_counter.sv
// Purpose: One PLL lock interval timer counting input clock cycles
// Assumes: load and count come from logic on the same clock
// Notes:   done is a one-cycle pulse at the end of the interval
module cdp_lock_counter
  import cdp_pkg::*;
(
  input  wire logic              clk,   // input clock
  input  wire logic              rst,   // sync reset
  input  wire logic              load,  // start interval
  input  wire logic [LOCK_W-1:0] count, // interval length
  output logic                   busy,  // interval running
  output logic                   done   // interval ended
);
  logic [LOCK_W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      busy    <= 1'b1;
      done    <= 1'b0;
    end else if (busy && cnt_reg == '0) begin
      busy <= 1'b0;
      done <= 1'b1;
    end else begin
      cnt_reg <= busy ? cnt_reg - 1'b1 : cnt_reg;
      done    <= 1'b0;
    end
  end
endmodule : cdp_lock_counter

// >>> hdl/cdp_tick_div.sv
// Purpose: Divides a tick stream by 1, 2 or 4
// Assumes: tickIn is a one-cycle enable pulse
// Notes:   restart realigns the phase when a new ratio is applied
module cdp_tick_div (
  input  wire logic       clk,     // input clock
  input  wire logic       rst,     // sync reset
  input  wire logic       restart, // clear phase
  input  wire logic       tickIn,  // source tick
  input  wire logic [1:0] sel,     // 0:/1 1:/2 2:/4
  output logic            tickOut  // divided tick
);
  logic [1:0] cnt_reg;
  logic [1:0] mask;

  always_comb begin
    case (sel)
      2'h1:    mask = 2'h1;
      2'h2:    mask = 2'h3;
      default: mask = 2'h0;
    endcase
  end

  assign tickOut = tickIn && ((cnt_reg & mask) == mask);

  always_ff @(posedge clk) begin
    if (rst || restart) begin
      cnt_reg <= 2'h0;
    end else if (tickIn) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end
endmodule : cdp_tick_div

// >>> hdl/cdp_clock_ctrl.sv
// Purpose: Clock source, ratio and power mode control with AHB-Lite registers
// Assumes: clk is the crystal or external input clock; PLL clocks are
//          represented by enables and source selects
// Notes:   Clock outputs are one-cycle enables, not clock edges
//
// Contract
// [RL1] New main PLL values start a lock interval with core clock gated. In slow mode the core keeps its slow clock instead.
// [RL2] USB clock: input clock, low during lock, then PLL, input clock when off; once configured, re-enable selects PLL at once, not held low.
// [RL3] Three ratio bits select core, bus and peripheral divide ratios.
// [RL4] Ratio written during lock applies at lock end, also at mode change.
// [RL5] Otherwise ratio applies after 1.5 bus periods, one from 1:1:1.
// [RL6] Halved bus with fast bus mode clocks the CPU from bus clock.
// [RL7] Normal and slow clock everything; idle stops CPU; power-off cuts all.
// [RL8] Software enable bits gate each peripheral clock; basic blocks stay clocked.
// [RL9] Idle returns to normal on external, alarm or other interrupt.
// [RL10] Slow core clock is input divided by one or twice the field.
// [RL11] Slow bus and peripheral clocks follow the halving bits.
// [RL12] Leaving slow with PLL off times lock while core stays slow.
// [RL13] Setting slow with PLL running switches at once, no lock.
// [RL14] Clearing slow after lock switches to PLL at once.
// [RL15] Clearing slow and PLL-off together waits for lock before PLL.
// [RL16] Power-off wakes only on external interrupts 15 to 0 or alarm.
// [RL17] Software programs the ratio after PLL values within frequency limits.
// [RL18] Software leaves fast bus mode when halving the bus clock.
// [RL19] After reset core clock is the input clock until PLL configured.
// [RL20] Lock count holds main count in 11:0, USB in 23:12, reset all ones.
// [RL21] Lock counters load on reprogram or enable and count input cycles.
module cdp_clock_ctrl
  import cdp_pkg::*;
(
  input  wire logic        clk,          // input clock, 25 MHz
  input  wire logic        rst,          // sync reset, active high
  input  wire logic        hsel,         // AHB select
  input  wire logic [31:0] haddr,        // AHB address
  input  wire logic [1:0]  htrans,       // AHB transfer type
  input  wire logic        hwrite,       // AHB write
  input  wire logic [2:0]  hsize,        // AHB size, word only
  input  wire logic [31:0] hwdata,       // AHB write data
  input  wire logic        hready,       // AHB bus ready
  output logic             hreadyout,    // AHB slave ready
  output logic [31:0]      hrdata,       // AHB read data
  output logic             hresp,        // AHB response, always OKAY
  input  wire logic [23:0] extIrqPin,    // external interrupt pins
  input  wire logic        rtcAlarmPin,  // alarm from the RTC domain
  input  wire logic        otherIrq,     // any other pending interrupt
  input  wire logic        fastBusMode,  // CPU bus interface in fast mode
  output logic             coreClkEn,    // core clock tick
  output logic             cpuClkEn,     // CPU core tick
  output logic             busClkEn,     // high-speed bus tick
  output logic             periphClkEn,  // peripheral bus tick
  output logic [15:0]      periphGateEn, // per-peripheral ticks
  output logic             coreFromPll,  // core clock taken from PLL
  output logic             mainPllOn,    // main PLL enable
  output logic [19:0]      mainPllCfg,   // main PLL divider values
  output logic             usbPllOn,     // USB PLL enable
  output logic [19:0]      usbPllCfg,    // USB PLL divider values
  output logic             usbClkFromPll,// USB clock from USB PLL
  output logic             usbClkRun,    // USB clock not held low
  output logic             powerEnable,  // core supply enable
  output logic             gpioHold      // hold pin states
);
  function automatic logic [3:0] ratioSel(input cdp_ratio_s r);
    case ({r.quarter, r.half, r.periph})
      3'h1:    ratioSel = 4'h1;
      3'h2:    ratioSel = 4'h4;
      3'h3:    ratioSel = 4'h5;
      3'h4:    ratioSel = 4'h8;
      default: ratioSel = 4'h0;
    endcase
  endfunction : ratioSel

  function automatic logic [3:0] slowDivisor(input logic [2:0] v);
    slowDivisor = (v == 3'h0) ? 4'h1 : {v, 1'b0};
  endfunction : slowDivisor

  logic        accept;
  logic        dWr_reg;
  logic        dRd_reg;
  logic [7:0]  dAddr_reg;
  logic        wrLock;
  logic        wrMcfg;
  logic        wrUcfg;
  logic        wrCtrl;
  logic        wrSlow;
  logic        wrRatio;
  logic [23:0] lock_count_reg;
  logic [19:0] mcfg_reg;
  logic [19:0] ucfg_reg;
  logic [15:0] periGate_reg;
  cdp_slow_s   slow_clock_ctrl_reg;
  cdp_slow_s   slowNext;
  cdp_ratio_s  clock_ratio_reg;
  cdp_ratio_s  ratioAct_reg;
  logic        mcfgDone_reg;
  logic        ucfgDone_reg;
  logic        pllOn_reg;
  logic        pllOnNext;
  cdp_core_e   core_reg;
  cdp_usb_e    usb_reg;
  cdp_mode_e   mode_reg;
  cdp_mode_e   modePrev_reg;
  logic [23:0] extMeta_reg;
  logic [23:0] extSync_reg;
  logic        rtcMeta_reg;
  logic        rtcSync_reg;
  logic        mainLoad;
  logic        mainBusy;
  logic        mainDone;
  logic        usbLoad;
  logic        usbBusy;
  logic        usbDone;
  logic        mainLocked;
  logic        locking;
  logic [3:0]  slowCnt_reg;
  logic        slowTick;
  logic        coreTick;
  logic        busTick;
  logic        perTick;
  logic [3:0]  sel;
  logic        pend_reg;
  logic        armed_reg;
  logic [1:0]  halfCnt_reg;
  logic        applyNow;

  // Register bus: writes take no wait state, reads one
  assign accept  = hsel && htrans[1] && hready;
  assign wrLock  = dWr_reg && dAddr_reg == OFS_LOCK;
  assign wrMcfg  = dWr_reg && dAddr_reg == OFS_MCFG;
  assign wrUcfg  = dWr_reg && dAddr_reg == OFS_UCFG;
  assign wrCtrl  = dWr_reg && dAddr_reg == OFS_CTRL;
  assign wrSlow  = dWr_reg && dAddr_reg == OFS_SLOW;
  assign wrRatio = dWr_reg && dAddr_reg == OFS_RATIO;
  assign slowNext = cdp_slow_s'(hwdata[7:0]);

  always_ff @(posedge clk) begin
    if (rst) begin
      dWr_reg   <= 1'b0;
      dRd_reg   <= 1'b0;
      dAddr_reg <= 8'h00;
    end else begin
      dWr_reg <= accept && hwrite;
      dRd_reg <= accept && !hwrite;
      if (accept) begin
        dAddr_reg <= haddr[7:0];
      end
    end
  end

  // The wait state covers read data, which is registered one cycle after the address phase
  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(accept && !hwrite);
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (dRd_reg) begin
      case (dAddr_reg)
        OFS_LOCK:  hrdata <= {8'h00, lock_count_reg};
        OFS_MCFG:  hrdata <= {12'h000, mcfg_reg};
        OFS_UCFG:  hrdata <= {12'h000, ucfg_reg};
        OFS_CTRL:  hrdata <= {14'h0000, mode_reg == PM_OFF, mode_reg == PM_IDLE, periGate_reg};
        OFS_SLOW:  hrdata <= {24'h000000, slow_clock_ctrl_reg};
        OFS_RATIO: hrdata <= {29'h00000000, clock_ratio_reg};
        OFS_STAT:  hrdata <= {19'h00000, lock_count_reg[11:0] < LOCK_MIN_CYC, ratioAct_reg,
                              mode_reg, usb_reg, core_reg, usbBusy, mainBusy};
        default:   hrdata <= 32'h00000000;
      endcase
    end
  end

  // Software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_count_reg <= LOCK_RST; // see [RL20]
    end else if (wrLock) begin
      lock_count_reg <= hwdata[23:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mcfg_reg     <= PLLCFG_RST;
      mcfgDone_reg <= 1'b0;
      ucfg_reg     <= PLLCFG_RST;
      ucfgDone_reg <= 1'b0;
    end else begin
      if (wrMcfg) begin
        mcfg_reg     <= hwdata[19:0];
        mcfgDone_reg <= 1'b1;
      end
      if (wrUcfg) begin
        ucfg_reg     <= hwdata[19:0];
        ucfgDone_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      periGate_reg <= PERI_RST;
    end else if (wrCtrl) begin
      periGate_reg <= hwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slow_clock_ctrl_reg <= cdp_slow_s'(SLOW_RST);
    end else if (wrSlow) begin
      slow_clock_ctrl_reg <= {slowNext.usbOff, 1'b0, slowNext.mainOff, slowNext.slowOn, 1'b0, slowNext.val};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_ratio_reg <= cdp_ratio_s'(RATIO_RST);
    end else if (wrRatio) begin
      clock_ratio_reg <= cdp_ratio_s'(hwdata[2:0]);
    end
  end

  // Wake sources come from other domains
  always_ff @(posedge clk) begin
    if (rst) begin
      extMeta_reg <= 24'h000000;
      extSync_reg <= 24'h000000;
      rtcMeta_reg <= 1'b0;
      rtcSync_reg <= 1'b0;
    end else begin
      extMeta_reg <= extIrqPin;
      extSync_reg <= extMeta_reg;
      rtcMeta_reg <= rtcAlarmPin;
      rtcSync_reg <= rtcMeta_reg;
    end
  end

  // Main PLL may only be off while slow mode is on
  assign pllOnNext = !(slowNext.slowOn && slowNext.mainOff);

  always_ff @(posedge clk) begin
    if (rst) begin
      pllOn_reg <= 1'b1;
    end else if (wrSlow) begin
      pllOn_reg <= pllOnNext;
    end
  end

  assign mainLoad   = (wrMcfg && pllOn_reg) || (wrSlow && !pllOn_reg && pllOnNext); // see [RL21]
  assign mainLocked = mcfgDone_reg && pllOn_reg && !mainBusy;
  assign usbLoad    = (wrUcfg && usb_reg != US_OFF) || (wrSlow && usb_reg == US_OFF && !slowNext.usbOff);

  cdp_lock_counter u_mainLock (
    .clk   (clk),
    .rst   (rst),
    .load  (mainLoad),
    .count (lock_count_reg[LOCK_M_LSB +: LOCK_W]),
    .busy  (mainBusy),
    .done  (mainDone)
  );

  cdp_lock_counter u_usbLock (
    .clk   (clk),
    .rst   (rst),
    .load  (usbLoad),
    .count (lock_count_reg[LOCK_U_LSB +: LOCK_W]),
    .busy  (usbBusy),
    .done  (usbDone)
  );

  // Core clock source
  always_ff @(posedge clk) begin
    if (rst) begin
      core_reg <= CS_XTAL; // see [RL19]
    end else if (wrSlow && slowNext.slowOn) begin
      core_reg <= CS_SLOW; // see [RL13]
    end else if (wrSlow && slow_clock_ctrl_reg.slowOn) begin
      if (mainLocked && pllOnNext) begin
        core_reg <= CS_PLL; // see [RL14]
      end else if (mcfgDone_reg) begin
        core_reg <= CS_SLOWLOCK; // see [RL12] see [RL15]
      end else begin
        core_reg <= CS_XTAL;
      end
    end else if (wrMcfg && (core_reg == CS_XTAL || core_reg == CS_PLL || core_reg == CS_LOCK)) begin
      core_reg <= CS_LOCK; // see [RL1]
    end else if (mainDone && (core_reg == CS_LOCK || core_reg == CS_SLOWLOCK)) begin
      core_reg <= CS_PLL; // see [RL19]
    end
  end

  // USB clock source
  always_ff @(posedge clk) begin
    if (rst) begin
      usb_reg <= US_XTAL; // see [RL2]
    end else if (wrSlow && slowNext.usbOff) begin
      usb_reg <= US_OFF; // see [RL2]
    end else if (wrSlow && usb_reg == US_OFF) begin
      usb_reg <= ucfgDone_reg ? US_PLL : US_XTAL; // see [RL2]
    end else if (wrUcfg && usb_reg != US_OFF) begin
      usb_reg <= US_LOCK; // see [RL2]
    end else if (usbDone && usb_reg == US_LOCK) begin
      usb_reg <= US_PLL;
    end
  end

  // Power mode; state loss of the real power-off is not modelled
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg     <= PM_RUN;
      modePrev_reg <= PM_RUN;
    end else begin
      modePrev_reg <= mode_reg;
      case (mode_reg)
        PM_RUN: begin
          if (wrCtrl && hwdata[CTRL_OFF]) begin
            mode_reg <= PM_OFF;
          end else if (wrCtrl && hwdata[CTRL_IDLE]) begin
            mode_reg <= PM_IDLE;
          end
        end
        PM_IDLE: begin
          if ((|extSync_reg) || rtcSync_reg || otherIrq) begin
            mode_reg <= PM_RUN; // see [RL9]
          end
        end
        PM_OFF: begin
          if ((|extSync_reg[15:0]) || rtcSync_reg) begin
            mode_reg <= PM_RUN; // see [RL16]
          end
        end
        default: mode_reg <= PM_RUN;
      endcase
    end
  end

  // Slow clock divider on the input clock
  assign slowTick = slowCnt_reg == slowDivisor(slow_clock_ctrl_reg.val) - 4'h1;

  always_ff @(posedge clk) begin
    if (rst || slowTick || wrSlow) begin
      slowCnt_reg <= 4'h0;
    end else begin
      slowCnt_reg <= slowCnt_reg + 4'h1; // see [RL10]
    end
  end

  always_comb begin
    case (core_reg)
      CS_XTAL, CS_PLL:      coreTick = mode_reg != PM_OFF; // see [RL7]
      CS_SLOW, CS_SLOWLOCK: coreTick = slowTick && mode_reg != PM_OFF; // see [RL10] see [RL12]
      default:              coreTick = 1'b0; // see [RL1]
    endcase
  end

  // Ratio application
  assign locking  = core_reg == CS_LOCK || core_reg == CS_SLOWLOCK;
  assign sel      = ratioSel(ratioAct_reg); // see [RL3]
  assign applyNow = pend_reg && (locking ? mainDone // see [RL4]
                    : (mode_reg != modePrev_reg) // see [RL4]
                    || (ratioAct_reg == cdp_ratio_s'(RATIO_RST) ? busTick // see [RL5]
                    : (armed_reg && halfCnt_reg == sel[3:2]))); // see [RL5]

  always_ff @(posedge clk) begin
    if (rst) begin
      ratioAct_reg <= cdp_ratio_s'(RATIO_RST);
      pend_reg     <= 1'b1;
      armed_reg    <= 1'b0;
      halfCnt_reg  <= 2'h0;
    end else begin
      if (applyNow) begin
        ratioAct_reg <= clock_ratio_reg;
      end
      pend_reg <= wrRatio || (pend_reg && !applyNow);
      if (applyNow || wrRatio) begin
        armed_reg   <= 1'b0;
        halfCnt_reg <= 2'h0;
      end else if (pend_reg && !locking && busTick) begin
        armed_reg   <= 1'b1;
        halfCnt_reg <= 2'h0;
      end else if (armed_reg && coreTick) begin
        halfCnt_reg <= halfCnt_reg + 2'h1;
      end
    end
  end

  cdp_tick_div u_busDiv (
    .clk     (clk),
    .rst     (rst),
    .restart (applyNow),
    .tickIn  (coreTick),
    .sel     (sel[3:2]),
    .tickOut (busTick) // see [RL3] see [RL11]
  );

  cdp_tick_div u_perDiv (
    .clk     (clk),
    .rst     (rst),
    .restart (applyNow),
    .tickIn  (busTick),
    .sel     (sel[1:0]),
    .tickOut (perTick) // see [RL3] see [RL11]
  );

  // Registered clock enables
  always_ff @(posedge clk) begin
    if (rst) begin
      coreClkEn    <= 1'b0;
      cpuClkEn     <= 1'b0;
      busClkEn     <= 1'b0;
      periphClkEn  <= 1'b0;
      periphGateEn <= 16'h0000;
    end else begin
      coreClkEn    <= coreTick;
      cpuClkEn     <= mode_reg == PM_RUN && ((ratioAct_reg.half && fastBusMode) ? busTick : coreTick); // see [RL6] see [RL7]
      busClkEn     <= busTick;
      periphClkEn  <= perTick;
      periphGateEn <= {16{perTick}} & periGate_reg; // see [RL8]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      coreFromPll   <= 1'b0;
      mainPllOn     <= 1'b1;
      mainPllCfg    <= PLLCFG_RST;
      usbPllOn      <= 1'b1;
      usbPllCfg     <= PLLCFG_RST;
      usbClkFromPll <= 1'b0;
      usbClkRun     <= 1'b1;
      powerEnable   <= 1'b1;
      gpioHold      <= 1'b0;
    end else begin
      coreFromPll   <= core_reg == CS_PLL;
      mainPllOn     <= pllOn_reg;
      mainPllCfg    <= mcfg_reg;
      usbPllOn      <= usb_reg != US_OFF;
      usbPllCfg     <= ucfg_reg;
      usbClkFromPll <= usb_reg == US_PLL; // see [RL2]
      usbClkRun     <= usb_reg != US_LOCK; // see [RL2]
      powerEnable   <= mode_reg != PM_OFF; // see [RL7]
      gpioHold      <= mode_reg == PM_OFF; // see [RL7]
    end
  end
endmodule : cdp_clock_ctrl

// >>> bench/cdp_tick_sink.sv
// Purpose: Clock consumer model counting the ticks it receives
// Assumes: ticks are one-cycle enables on clk
// Notes:   clr zeroes all counts at the next edge
module cdp_tick_sink
  import cdp_pkg::*;
(
  input  wire logic        clk,          // clock
  input  wire logic        clr,          // clear counts
  input  wire logic        coreClkEn,    // core tick
  input  wire logic        cpuClkEn,     // cpu tick
  input  wire logic        busClkEn,     // bus tick
  input  wire logic        periphClkEn,  // periph tick
  input  wire logic [15:0] periphGateEn, // gated ticks
  output logic      [31:0] nCore,        // core count
  output logic      [31:0] nCpu,         // cpu count
  output logic      [31:0] nBus,         // bus count
  output logic      [31:0] nPer,         // periph count
  output logic      [15:0] gateSeen      // gates that ticked
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge clk) begin
    if (clr) begin
      nCore    <= 32'h0;
      nCpu     <= 32'h0;
      nBus     <= 32'h0;
      nPer     <= 32'h0;
      gateSeen <= 16'h0;
    end else begin
      nCore    <= nCore + 32'(coreClkEn);
      nCpu     <= nCpu + 32'(cpuClkEn);
      nBus     <= nBus + 32'(busClkEn);
      nPer     <= nPer + 32'(periphClkEn);
      gateSeen <= gateSeen | periphGateEn;
    end
  end
endmodule : cdp_tick_sink

// >>> bench/cdp_clock_ctrl_props.sv
// Purpose: Port assertions for the clock control block
// Assumes: one clock domain, sync reset
// Notes:   bound to the design below the module
module cdp_clock_ctrl_props (
  input wire logic        clk,          // clock
  input wire logic        rst,          // reset
  input wire logic        hsel,         // select
  input wire logic [1:0]  htrans,       // type
  input wire logic        hwrite,       // write
  input wire logic        hready,       // ready in
  input wire logic        hreadyout,    // ready out
  input wire logic        hresp,        // response
  input wire logic        coreClkEn,    // core tick
  input wire logic        cpuClkEn,     // cpu tick
  input wire logic        busClkEn,     // bus tick
  input wire logic        periphClkEn,  // periph tick
  input wire logic [15:0] periphGateEn, // gated ticks
  input wire logic        coreFromPll,  // pll source
  input wire logic        mainPllOn,    // pll enable
  input wire logic        powerEnable,  // supply
  input wire logic        gpioHold      // pin hold
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence sTaken;
    hsel && htrans[1] && hready;
  endsequence
  sequence sRdWait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (!hresp) else $error("response not okay");
  a_read_wait: assert property (sTaken ##0 !hwrite |=> sRdWait) else $error("read wait wrong");
  a_write_fast: assert property (sTaken ##0 hwrite |=> hreadyout) else $error("write stalled");
  a_bus_in_core: assert property (busClkEn |-> coreClkEn) else $error("bus tick off core");
  a_per_in_bus: assert property (periphClkEn |-> busClkEn) else $error("periph tick off bus");
  a_gate_per: assert property (|periphGateEn |-> periphClkEn) else $error("gate without tick");
  a_pll_on: assert property (coreFromPll |-> mainPllOn) else $error("core on stopped pll");
  a_off_quiet: assert property (!powerEnable |-> gpioHold && !cpuClkEn && !busClkEn)
    else $error("power-off not quiet");
  a_reset_src: assert property ($fell(rst) |-> !coreFromPll ##[1:2] coreClkEn)
    else $error("reset source wrong");
endmodule : cdp_clock_ctrl_props

bind cdp_clock_ctrl cdp_clock_ctrl_props props_i (.*);

// >>> bench/testbench.sv
// Purpose: Self-checking bench for the clock control block
// Assumes: lock counts shortened to 5 through the register
// Notes:   tick counts come from the consumer model
module testbench
  import cdp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, rtcAlarmPin, otherIrq, fastBusMode, clr;
  logic coreClkEn, cpuClkEn, busClkEn, periphClkEn, coreFromPll, mainPllOn, usbPllOn;
  logic usbClkFromPll, usbClkRun, powerEnable, gpioHold;
  logic [31:0] haddr, hwdata, hrdata, rd, nCore, nCpu, nBus, nPer;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [23:0] extIrqPin;
  logic [15:0] periphGateEn, gateSeen;
  logic [19:0] mainPllCfg, usbPllCfg;
  int          errCount, nTests, cyc;
  assign hready = hreadyout;

  cdp_clock_ctrl cdp_clock_ctrl_i (.*);
  cdp_tick_sink cdp_tick_sink_i (.*);

  task print_verdict();
    if (errCount == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Single word transfer; read data lands in rd
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Count ticks over n edges
  task win(input int n);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask : win

  task t_reset();
    bus(1'b0, OFS_LOCK, 32'h0);
    chk(rd, 32'h00ffffff);
    bus(1'b0, OFS_RATIO, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    win(12);
    chk(coreFromPll, 1'b0);
    chk(nCore, 32'd12);
  endtask : t_reset

  task t_lock();
    bus(1'b1, OFS_LOCK, 32'h5005);
    bus(1'b1, OFS_MCFG, 32'h1);
    win(4);
    chk(nCore, 32'h0);
    chk(mainPllCfg, 32'h1);
    repeat (4) @(posedge clk);
    win(20);
    chk(nCore, 32'd20);
    chk(coreFromPll, 1'b1);
  endtask : t_lock

  task t_usb();
    bus(1'b1, OFS_UCFG, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk(usbClkRun, 1'b0);
    chk(usbPllCfg, 32'h1);
    repeat (12) @(posedge clk);
    #1 chk({usbClkRun, usbClkFromPll}, 2'h3);
    bus(1'b1, OFS_SLOW, 32'h80);
    repeat (3) @(posedge clk);
    #1 chk({usbPllOn, usbClkFromPll}, 2'h0);
    bus(1'b1, OFS_SLOW, 32'h0);
    repeat (3) @(posedge clk);
    #1 chk({usbPllOn, usbClkFromPll}, 2'h3);
  endtask : t_usb

  task automatic t_ratio();
    int eb [5] = '{48, 48, 24, 24, 12};
    int ep [5] = '{48, 24, 24, 12, 12};
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, OFS_RATIO, 32'(i));
      fastBusMode <= (i == 2);
      repeat (16) @(posedge clk);
      win(48);
      chk(nBus, eb[i]);
      chk(nPer, ep[i]);
      chk(nCpu, (i == 2) ? eb[i] : 48);
    end
    bus(1'b1, OFS_RATIO, 32'h0);
    fastBusMode <= 1'b0;
  endtask : t_ratio

  task automatic t_slow();
    int dv [4] = '{1, 2, 4, 6};
    for (int v = 0; v < 4; v++) begin
      bus(1'b1, OFS_SLOW, 32'h10 | 32'(v));
      repeat (8) @(posedge clk);
      win(84);
      chk(coreFromPll, 1'b0);
      chk(nCore, 84 / dv[v]);
      chk(nBus, 84 / dv[v]);
    end
    bus(1'b1, OFS_SLOW, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk(coreFromPll, 1'b1);
  endtask : t_slow

  task t_relock();
    bus(1'b1, OFS_SLOW, 32'h33);
    repeat (3) @(posedge clk);
    #1 chk(mainPllOn, 1'b0);
    bus(1'b1, OFS_SLOW, 32'h0);
    repeat (2) @(posedge clk);
    #1 chk({mainPllOn, coreFromPll}, 2'h2);
    repeat (12) @(posedge clk);
    #1 chk(coreFromPll, 1'b1);
  endtask : t_relock

  // Each wake source in turn: other, external line 20, alarm
  task t_idle();
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, OFS_CTRL, 32'h1fffe);
      win(12);
      chk(nCpu, 32'h0);
      chk(nCore, 32'd12);
      chk(gateSeen, 16'hfffe);
      @(posedge clk);
      {rtcAlarmPin, extIrqPin[20], otherIrq} <= 3'(1 << k);
      repeat (4) @(posedge clk);
      {rtcAlarmPin, extIrqPin[20], otherIrq} <= 3'h0;
      win(10);
      chk(nCpu, 32'd10);
    end
  endtask : t_idle

  task t_off();
    bus(1'b1, OFS_CTRL, 32'h2ffff);
    @(posedge clk);
    extIrqPin <= 24'h100000;
    repeat (8) @(posedge clk);
    #1 chk({powerEnable, gpioHold}, 2'h1);
    @(posedge clk);
    extIrqPin <= 24'h8;
    repeat (6) @(posedge clk);
    extIrqPin <= 24'h0;
    #1 chk({powerEnable, gpioHold}, 2'h2);
  endtask : t_off

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errCount++;
      print_verdict();
    end
  end

  initial begin
    {rst, hsel, hwrite, rtcAlarmPin, otherIrq, fastBusMode, clr} = 7'h40;
    {haddr, hwdata, htrans, extIrqPin} = '0;
    hsize = 3'h2;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_lock();
    t_usb();
    t_ratio();
    t_slow();
    t_relock();
    t_idle();
    t_off();
    print_verdict();
  end
endmodule : testbench
